// *** hw/dif_pkg.sv ***
package dif_pkg;

   // ------------------------------------------------------------
   // Terminal count and function codes
   // ------------------------------------------------------------
   localparam int NUM_TERMS = 6;
   localparam int CODE_W = 5;
   localparam int NUM_CODES = 18;
   localparam logic [4:0] FN_NONE = 5'h00;
   localparam logic [4:0] FN_SPEED1 = 5'h01;
   localparam logic [4:0] FN_FAULT_RESET = 5'h05;
   localparam logic [4:0] FN_RAMP_HOLD = 5'h06;
   localparam logic [4:0] FN_RAMP_SET = 5'h07;
   localparam logic [4:0] FN_JOG = 5'h08;
   localparam logic [4:0] FN_BASE_BLOCK = 5'h09;
   localparam logic [4:0] FN_FREQ_UP = 5'h0a;
   localparam logic [4:0] FN_FREQ_DOWN = 5'h0b;
   localparam logic [4:0] FN_COUNT_TRIG = 5'h0c;
   localparam logic [4:0] FN_COUNT_RESET = 5'h0d;
   localparam logic [4:0] FN_EXT_FAULT = 5'h0e;
   localparam logic [4:0] FN_PID_OFF = 5'h0f;
   localparam logic [4:0] FN_SHUTOFF = 5'h10;
   localparam logic [4:0] FN_PARAM_LOCK = 5'h11;
   localparam logic [4:0] FN_MAX = 5'h11;
   localparam logic [4:0] SEL_RESET = 5'h00;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] ADR_SEL_FIRST = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h18;
   localparam logic [7:0] ADR_COUNT = 8'h1c;
   localparam int COUNT_W = 16;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // Status field positions
   localparam int ST_SPEED_LSB = 0;
   localparam int ST_RAMP_HOLD = 4;
   localparam int ST_RAMP_SET = 5;
   localparam int ST_JOG = 6;
   localparam int ST_BLOCK = 7;
   localparam int ST_SEARCH = 8;
   localparam int ST_EXT_FAULT = 9;
   localparam int ST_PID_OFF = 10;
   localparam int ST_SHUTOFF = 11;
   localparam int ST_LOCK = 12;
   localparam int ST_TERM_LSB = 16;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int UPDN_REPEAT_MS = 50;
   localparam int UPDN_REPEAT_CYC = UPDN_REPEAT_MS * (CLK_HZ / 1000);

endpackage : dif_pkg

// *** hw/dif_decoder.sv ***
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

// Behaviour
// - Codes 1 to 4 form a four-bit preset speed selector.
// - Code 5 resets a latched fault once its cause is gone.
// - Code 6 freezes the ramp while active.
// - Code 7 picks one of two ramp time sets.
// - Code 8 commands jog; assigning it is allowed only when stopped.
// - Code 9 blocks all power output at once.
// - Base block release starts speed search, then ramp to master.
// - Codes 10 and 11 step frequency per pulse and repeatedly while held.
// - Both raise and lower active together halts frequency change.
// - Each code 12 pulse adds exactly one to the counter.
// - Code 13 holds the counter cleared; party must release to count.
// - Code 14 raises the external fault condition.
// - Code 15 keeps PID disabled while active.
// - Code 16 shuts output off; on release restart from 0 Hz.
// - Code 17 locks parameters and rejects all parameter writes.
// - Each of six terminals has its own function select register.
module dif_decoder #(
   parameter int NUM_TERMS = dif_pkg::NUM_TERMS,
   parameter int UPDN_REPEAT_CYC = dif_pkg::UPDN_REPEAT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [NUM_TERMS-1:0] ext_in_i,
   input wire logic motor_stopped_i,
   input wire logic fault_cause_gone_i,
   input wire logic search_done_i,
   output logic [3:0] speed_sel_o,
   output logic fault_reset_o,
   output logic ramp_hold_o,
   output logic ramp_set_sel_o,
   output logic jog_o,
   output logic output_block_o,
   output logic speed_search_o,
   output logic freq_up_o,
   output logic freq_down_o,
   output logic [dif_pkg::COUNT_W-1:0] count_o,
   output logic ext_fault_o,
   output logic pid_disable_o,
   output logic shutoff_o,
   output logic restart_zero_o,
   output logic param_lock_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (NUM_TERMS < 1 || NUM_TERMS > 6) begin : g_bad_terms
      $error("NUM_TERMS must be 1 to 6");
   end
   if (UPDN_REPEAT_CYC < 2) begin : g_bad_rep
      $error("UPDN_REPEAT_CYC must be at least 2");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [NUM_TERMS-1:0] sync1;
   logic [NUM_TERMS-1:0] sync2;
   logic [dif_pkg::CODE_W-1:0] fsel [NUM_TERMS];
   logic [dif_pkg::NUM_CODES-1:0] hot [NUM_TERMS];
   logic [dif_pkg::NUM_CODES-1:0] act;
   logic [dif_pkg::NUM_CODES-1:0] act_q;
   logic [dif_pkg::NUM_CODES-1:0] rise;
   logic [dif_pkg::NUM_CODES-1:0] fall;
   logic wr_take;
   logic wr_ok;
   logic [5:0] reg_idx;
   logic [31:0] next_dat;
   logic [31:0] status_word;
   logic [31:0] rep_cnt;
   logic up_only;
   logic down_only;

   // ------------------------------------------------------------
   // Terminal synchronisers
   // ------------------------------------------------------------
   // Two stages before any logic reads a terminal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= ext_in_i;
         sync2 <= sync1;
      end
   end

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   // Request decode; one-cycle ack
   assign reg_idx = adr_i[7:2];
   assign wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   // Locked or jog-while-running writes are dropped but still acked
   assign wr_ok = wr_take && !act[dif_pkg::FN_PARAM_LOCK]
      && !(dat_i[4:0] == dif_pkg::FN_JOG && !motor_stopped_i);

   // Status word assembly
   always_comb begin
      status_word = '0;
      status_word[dif_pkg::ST_SPEED_LSB +: 4] = speed_sel_o;
      status_word[dif_pkg::ST_RAMP_HOLD] = ramp_hold_o;
      status_word[dif_pkg::ST_RAMP_SET] = ramp_set_sel_o;
      status_word[dif_pkg::ST_JOG] = jog_o;
      status_word[dif_pkg::ST_BLOCK] = output_block_o;
      status_word[dif_pkg::ST_SEARCH] = speed_search_o;
      status_word[dif_pkg::ST_EXT_FAULT] = ext_fault_o;
      status_word[dif_pkg::ST_PID_OFF] = pid_disable_o;
      status_word[dif_pkg::ST_SHUTOFF] = shutoff_o;
      status_word[dif_pkg::ST_LOCK] = param_lock_o;
      status_word[dif_pkg::ST_TERM_LSB +: NUM_TERMS] = sync2;
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      next_dat = '0;
      if (adr_i == dif_pkg::ADR_STATUS) begin
         next_dat = status_word;
      end else if (adr_i == dif_pkg::ADR_COUNT) begin
         next_dat[dif_pkg::COUNT_W-1:0] = count_o;
      end else if (adr_i[1:0] == 2'h0 && reg_idx < 6'(NUM_TERMS)) begin
         next_dat[dif_pkg::CODE_W-1:0] = fsel[reg_idx[2:0]];
      end
   end

   // Ack and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         dat_o <= next_dat;
      end
   end

   // ------------------------------------------------------------
   // Function select registers and code decode
   // ------------------------------------------------------------
   for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
      localparam logic [7:0] ADR_T = 8'(dif_pkg::ADR_SEL_FIRST + 8'(4 * t));
      // One select register per terminal
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            fsel[t] <= dif_pkg::SEL_RESET;
         end else if (wr_ok && adr_i == ADR_T) begin
            fsel[t] <= dat_i[dif_pkg::CODE_W-1:0];
         end
      end
      // Code 0 and codes above the last decode to nothing
      assign hot[t] = (sync2[t] && fsel[t] != dif_pkg::FN_NONE
         && fsel[t] <= dif_pkg::FN_MAX)
         ? (18'h00001 << fsel[t]) : 18'h00000;
   end

   // Terminals sharing a code are ORed
   always_comb begin
      act = '0;
      for (int t = 0; t < NUM_TERMS; t++) begin
         act = act | hot[t];
      end
   end

   // Previous levels for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_q <= '0;
      end else begin
         act_q <= act;
      end
   end
   assign rise = act & ~act_q;
   assign fall = ~act & act_q;

   // ------------------------------------------------------------
   // Level functions
   // ------------------------------------------------------------
   // Speed select, ramp, jog, fault, PID, lock levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_sel_o <= 4'h0;
         ramp_hold_o <= 1'b0;
         ramp_set_sel_o <= 1'b0;
         jog_o <= 1'b0;
         ext_fault_o <= 1'b0;
         pid_disable_o <= 1'b0;
         param_lock_o <= 1'b0;
      end else begin
         speed_sel_o <= act[4:1];
         ramp_hold_o <= act[dif_pkg::FN_RAMP_HOLD];
         ramp_set_sel_o <= act[dif_pkg::FN_RAMP_SET];
         jog_o <= act[dif_pkg::FN_JOG];
         ext_fault_o <= act[dif_pkg::FN_EXT_FAULT];
         pid_disable_o <= act[dif_pkg::FN_PID_OFF];
         param_lock_o <= act[dif_pkg::FN_PARAM_LOCK];
      end
   end

   // Fault reset pulse, only with the cause gone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_reset_o <= 1'b0;
      end else begin
         fault_reset_o <= rise[dif_pkg::FN_FAULT_RESET] && fault_cause_gone_i;
      end
   end

   // ------------------------------------------------------------
   // Base block, speed search and shutoff
   // ------------------------------------------------------------
   // Block output and run speed search after release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_block_o <= 1'b0;
         speed_search_o <= 1'b0;
      end else begin
         output_block_o <= act[dif_pkg::FN_BASE_BLOCK];
         if (act[dif_pkg::FN_BASE_BLOCK]) begin
            speed_search_o <= 1'b0;
         end else if (fall[dif_pkg::FN_BASE_BLOCK]) begin
            speed_search_o <= 1'b1;
         end else if (search_done_i) begin
            speed_search_o <= 1'b0;
         end
      end
   end

   // Output shutoff with restart from zero on release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shutoff_o <= 1'b0;
         restart_zero_o <= 1'b0;
      end else begin
         shutoff_o <= act[dif_pkg::FN_SHUTOFF];
         restart_zero_o <= fall[dif_pkg::FN_SHUTOFF];
      end
   end

   // ------------------------------------------------------------
   // Frequency raise and lower
   // ------------------------------------------------------------
   assign up_only = act[dif_pkg::FN_FREQ_UP] && !act[dif_pkg::FN_FREQ_DOWN];
   assign down_only = act[dif_pkg::FN_FREQ_DOWN] && !act[dif_pkg::FN_FREQ_UP];

   // Step on each edge, then again every repeat period while held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rep_cnt <= '0;
         freq_up_o <= 1'b0;
         freq_down_o <= 1'b0;
      end else if (!(up_only || down_only)) begin
         rep_cnt <= '0;
         freq_up_o <= 1'b0;
         freq_down_o <= 1'b0;
      end else if (rise[dif_pkg::FN_FREQ_UP] || rise[dif_pkg::FN_FREQ_DOWN]
            || rep_cnt == 32'h0) begin
         rep_cnt <= 32'(UPDN_REPEAT_CYC - 1);
         freq_up_o <= up_only;
         freq_down_o <= down_only;
      end else begin
         rep_cnt <= rep_cnt - 32'h1;
         freq_up_o <= 1'b0;
         freq_down_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Event counter
   // ------------------------------------------------------------
   // Reset input holds it at zero and masks pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= dif_pkg::COUNT_RESET;
      end else if (act[dif_pkg::FN_COUNT_RESET]) begin
         count_o <= dif_pkg::COUNT_RESET;
      end else if (rise[dif_pkg::FN_COUNT_TRIG]) begin
         count_o <= count_o + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_bb_release;
      act[dif_pkg::FN_BASE_BLOCK] ##1 !act[dif_pkg::FN_BASE_BLOCK];
   endsequence

   sequence s_count_pulse;
      !act[dif_pkg::FN_COUNT_TRIG] ##1 act[dif_pkg::FN_COUNT_TRIG]
         && !act[dif_pkg::FN_COUNT_RESET];
   endsequence

   a_speed_select: assert property (act[4:1] != 4'h0 |=> speed_sel_o == $past(act[4:1]))
      else $error("preset speed selector does not follow terminals");
   a_fault_reset: assert property (
      rise[dif_pkg::FN_FAULT_RESET] && !fault_cause_gone_i |=> !fault_reset_o)
      else $error("fault reset issued while cause present");
   a_ramp_hold: assert property (
      act[dif_pkg::FN_RAMP_HOLD] [*2] |-> ramp_hold_o)
      else $error("ramp not held while hold input active");
   a_jog_reject: assert property (wr_take && adr_i == dif_pkg::ADR_SEL_FIRST
      && dat_i[4:0] == dif_pkg::FN_JOG && !motor_stopped_i |=> $stable(fsel[0]))
      else $error("jog code accepted while motor running");
   a_block_out: assert property (
      act[dif_pkg::FN_BASE_BLOCK] |=> output_block_o && !speed_search_o)
      else $error("output not blocked during base block");
   a_search_start: assert property (s_bb_release |=> speed_search_o)
      else $error("speed search not started on base block release");
   a_search_hold: assert property (speed_search_o && !search_done_i
      && !act[dif_pkg::FN_BASE_BLOCK] |=> speed_search_o)
      else $error("speed search ended before lock");
   a_updn_step: assert property (rise[dif_pkg::FN_FREQ_UP] && up_only
      |=> freq_up_o ##1 !freq_up_o)
      else $error("raise edge did not give one step");
   a_updn_halt: assert property (act[dif_pkg::FN_FREQ_UP] && act[dif_pkg::FN_FREQ_DOWN]
      |=> !freq_up_o && !freq_down_o)
      else $error("frequency changed with both inputs active");
   a_count_step: assert property (s_count_pulse |=> count_o == $past(count_o) + 16'h0001)
      else $error("counter did not add one per pulse");
   a_count_clear: assert property (act[dif_pkg::FN_COUNT_RESET] |=> count_o == 16'h0000)
      else $error("counter not held clear");
   a_restart_zero: assert property (shutoff_o && !act[dif_pkg::FN_SHUTOFF]
      |=> restart_zero_o && !shutoff_o)
      else $error("no restart from zero after shutoff release");
   a_lock_reject: assert property (wr_take && act[dif_pkg::FN_PARAM_LOCK]
      |=> $stable(fsel[0]))
      else $error("parameter written while locked");

endmodule : dif_decoder

// *** tb/dif_switches.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Contacts wired to the terminals
// ----------------------------------------
module dif_switches (
   input wire logic clk_i,
   output logic [5:0] ext_o
);
   initial ext_o = 6'h00;

   // Contact level, changed just after an edge
   task set_level(input int idx, input logic v);
      @(posedge clk_i);
      ext_o[idx] <= v;
   endtask : set_level

   // Closure of three cycles, then open long enough for the synchroniser
   task pulse(input int idx);
      set_level(idx, 1'b1);
      repeat (2) @(posedge clk_i);
      set_level(idx, 1'b0);
      repeat (3) @(posedge clk_i);
   endtask : pulse
endmodule : dif_switches

// *** tb/drive_input_function_decoder_bench.sv ***
`timescale 1ns/1ps

module drive_input_function_decoder_bench;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hf, wsel = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, stopped = 1'b1, cause_gone = 1'b0, search_done = 1'b0;
   logic [5:0] ext;
   logic [3:0] speed_sel_o;
   logic [15:0] count_o;
   logic fr_o, hold_o, rset_o, jog_o, blk_o, srch_o, up_o, dn_o;
   logic ef_o, pid_o, shut_o, rz_o, lock_o;
   logic [7:0] lv;
   int num_errors = 0, checks_done = 0, n_up = 0, n_dn = 0, n_fr = 0, n_rz = 0, b;
   int codes[8] = '{6, 7, 8, 9, 14, 15, 16, 17};

   always #12.5 clk_i = ~clk_i;
   assign lv = {lock_o, shut_o, pid_o, ef_o, blk_o, jog_o, rset_o, hold_o};

   dif_switches sw (.clk_i(clk_i), .ext_o(ext));

   dif_decoder #(.UPDN_REPEAT_CYC(8)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ext_in_i(ext), .motor_stopped_i(stopped), .fault_cause_gone_i(cause_gone),
      .search_done_i(search_done), .speed_sel_o(speed_sel_o), .fault_reset_o(fr_o),
      .ramp_hold_o(hold_o), .ramp_set_sel_o(rset_o), .jog_o(jog_o),
      .output_block_o(blk_o), .speed_search_o(srch_o), .freq_up_o(up_o),
      .freq_down_o(dn_o), .count_o(count_o), .ext_fault_o(ef_o), .pid_disable_o(pid_o),
      .shutoff_o(shut_o), .restart_zero_o(rz_o), .param_lock_o(lock_o));

   // Pulse tallies, taken mid-cycle away from the launching edge
   always @(negedge clk_i) begin
      if (up_o === 1'b1) n_up++;
      if (dn_o === 1'b1) n_dn++;
      if (fr_o === 1'b1) n_fr++;
      if (rz_o === 1'b1) n_rz++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task results;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // Classic single Wishbone cycle, bounded wait for ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= wsel;
      adr_i <= a;
      dat_i <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (i == 20) begin
         num_errors++;
         results();
      end
   endtask : wb

   task rd_check(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_check

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      tick(10);
      rst_i <= 1'b0;
      for (int t = 0; t < 9; t++) rd_check(8'(4 * t), 32'h0);
      for (int t = 0; t < 4; t++) wb(1'b1, 8'(4 * t), 32'(t + 1));
      for (int t = 0; t < 4; t++) rd_check(8'(4 * t), 32'(t + 1));
      sw.set_level(1, 1'b1);
      sw.set_level(3, 1'b1);
      tick(4);
      check({28'h0, speed_sel_o}, 32'ha);
      rd_check(8'h18, 32'h000a000a);
      sw.set_level(1, 1'b0);
      sw.set_level(3, 1'b0);
      wb(1'b1, 8'h10, 32'hc);
      wb(1'b1, 8'h14, 32'hd);
      for (int k = 0; k < 3; k++) sw.pulse(4);
      check({16'h0, count_o}, 32'h3);
      sw.set_level(5, 1'b1);
      tick(4);
      sw.pulse(4);
      check({16'h0, count_o}, 32'h0);
      sw.set_level(5, 1'b0);
      tick(4);
      sw.pulse(4);
      check({16'h0, count_o}, 32'h1);
      rd_check(8'h1c, 32'h1);
      for (int t = 0; t < 6; t++) wb(1'b1, 8'(4 * t), 32'h0);
      // Level functions one after another on the first terminal
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 8'h00, 32'(codes[i]));
         b = n_rz;
         sw.set_level(0, 1'b1);
         tick(4);
         check({24'h0, lv}, 32'(1 << i));
         if (codes[i] == 17) begin
            wb(1'b1, 8'h04, 32'h3);
            rd_check(8'h04, 32'h0);
            wb(1'b1, 8'h00, 32'h3);
            rd_check(8'h00, 32'h11);
         end
         sw.set_level(0, 1'b0);
         tick(4);
         check({24'h0, lv}, 32'h0);
         if (codes[i] == 16) check(n_rz - b, 1);
         if (codes[i] == 9) begin
            check({31'h0, srch_o}, 32'h1);
            search_done <= 1'b1;
            tick(4);
            search_done <= 1'b0;
            check({31'h0, srch_o}, 32'h0);
         end
      end
      stopped <= 1'b0;
      wb(1'b1, 8'h00, 32'h8);
      rd_check(8'h00, 32'h11);
      // Raise and lower
      wb(1'b1, 8'h00, 32'ha);
      wb(1'b1, 8'h04, 32'hb);
      b = n_up;
      sw.set_level(0, 1'b1);
      tick(24);
      check(n_up - b, 3);
      sw.set_level(1, 1'b1);
      tick(4);
      b = n_up + n_dn;
      tick(24);
      check(n_up + n_dn - b, 0);
      sw.set_level(0, 1'b0);
      sw.set_level(1, 1'b0);
      tick(4);
      b = n_dn;
      sw.pulse(1);
      check(n_dn - b, 1);
      // Writes without byte lane 0 are dropped
      wsel = 4'he;
      wb(1'b1, 8'h08, 32'h5);
      wsel = 4'hf;
      rd_check(8'h08, 32'h0);
      // Fault reset gated by the cause
      wb(1'b1, 8'h08, 32'h5);
      b = n_fr;
      sw.pulse(2);
      check(n_fr - b, 0);
      cause_gone <= 1'b1;
      sw.pulse(2);
      check(n_fr - b, 1);
      // Mid-run reset clears selects and counter
      rst_i <= 1'b1;
      tick(3);
      rst_i <= 1'b0;
      rd_check(8'h08, 32'h0);
      rd_check(8'h1c, 32'h0);
      results();
   end
endmodule : drive_input_function_decoder_bench
